// ### core/sfrb_pkg.sv
// Package for the bank-1 special register map: offsets, layouts, reset values.
// Assumes an APB slave with one register per aligned 32-bit word.
package sfrb_pkg;
	// ****************************************
	// Register indices (byte address is four times the index)
	// ****************************************
	localparam logic [7:0] IDX_INDIRECT_ACCESS_PORT = 8'h80;
	localparam logic [7:0] IDX_OPTION_CONFIG = 8'h81;
	localparam logic [7:0] IDX_PROGRAM_COUNTER_LOW = 8'h82;
	localparam logic [7:0] IDX_CORE_FLAGS = 8'h83;
	localparam logic [7:0] IDX_INDIRECT_POINTER = 8'h84;
	localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
	localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h86;
	localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h87;
	localparam logic [7:0] IDX_PC_UPPER_HOLDING = 8'h8a;
	localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h8b;
	localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLE = 8'h8c;
	localparam logic [7:0] IDX_POWER_RESET_CAUSE = 8'h8e;
	localparam logic [7:0] IDX_TIMER_PERIOD = 8'h92;
	localparam logic [7:0] IDX_SERIAL_SLAVE_ADDRESS = 8'h93;
	localparam logic [7:0] IDX_SERIAL_PORT_FLAGS = 8'h94;
	// Own registers: event status and mask
	localparam logic [7:0] IDX_EVENT_STATUS = 8'hc0;
	localparam logic [7:0] IDX_EVENT_MASK = 8'hc1;
	// Bank select bit within core_flags, and bank bit of the index
	localparam int CORE_FLAGS_BANK_BIT = 5;
	localparam int IDX_BANK_BIT = 7;
	// ****************************************
	// Reset values (power-on/brown-out column; other column noted)
	// ****************************************
	localparam logic [7:0] RST_OPTION_CONFIG = 8'hff;
	localparam logic [7:0] RST_PROGRAM_COUNTER_LOW = 8'h00;
	localparam logic [7:0] RST_CORE_FLAGS_POR = 8'h18;
	localparam logic [7:0] RST_INDIRECT_POINTER = 8'h00;
	localparam logic [5:0] RST_PORT_A_DIRECTION = 6'h3f;
	localparam logic [7:0] RST_PORT_B_DIRECTION = 8'hff;
	localparam logic [7:0] RST_PORT_C_DIRECTION = 8'hff;
	localparam logic [4:0] RST_PC_UPPER_HOLDING = 5'h00;
	localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
	localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] RST_TIMER_PERIOD = 8'hff;
	localparam logic [7:0] RST_SERIAL_SLAVE_ADDRESS = 8'h00;
	localparam logic [7:0] RST_SERIAL_PORT_FLAGS = 8'h00;
	// Core flags: top three bits cleared on every reset, low bits kept on other resets
	localparam logic [7:0] CORE_FLAGS_OTHER_CLEAR = 8'h1f;
	// Interrupt control: flag bit 0 kept on other resets
	localparam logic [7:0] INTCTL_KEEP_MASK = 8'h01;
	// Power cause bit positions
	localparam int PWR_POR_BIT = 1;
	localparam int PWR_BOR_BIT = 0;
	// Implemented bit mask of serial_port_flags
	localparam logic [7:0] SERIAL_FLAGS_MASK = 8'h3f;
	// Event bits
	localparam int EV_PC_LOAD = 0;
	localparam int EV_OTHER_RESET = 1;
	localparam int EV_UNMAPPED = 2;
	localparam int EV_WIDTH = 3;
endpackage

// ### core/sfrb_bank.sv
// Bank-1 special register map with APB access, indirect port and PC upper latch.
// Assumes a data memory on the mem_* ports answering combinationally to mem_rd,
// and reset cause pins already synchronous to pclk except the external reset pin.
`timescale 1ns/1ps
`default_nettype none
module sfrb_bank #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_reset_pin_n,
	input wire logic watchdog_timeout,
	input wire logic brownout_detect,
	output logic [8:0] mem_addr,
	output logic mem_wr,
	output logic mem_rd,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	output logic [12:0] program_counter,
	output logic [7:0] option_out,
	output logic [5:0] port_a_dir,
	output logic [7:0] port_b_dir,
	output logic [7:0] port_c_dir,
	output logic [7:0] irq_enable_out,
	output logic [7:0] timer_period_out,
	output logic [7:0] serial_addr_out,
	input wire logic [7:0] serial_flags_in,
	output logic irq
);
	import sfrb_pkg::*;

	// ****************************************
	// Reset cause capture
	// ****************************************
	logic ext_s1_q, ext_s2_q, ext_prev_q;
	logic other_reset;

	// Pin synchroniser; first stage read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 1'b1;
			ext_s2_q <= 1'b1;
			ext_prev_q <= 1'b1;
		end else begin
			ext_s1_q <= external_reset_pin_n;
			ext_s2_q <= ext_s1_q;
			ext_prev_q <= ext_s2_q;
		end
	end

	assign other_reset = (ext_prev_q && !ext_s2_q) || watchdog_timeout;

	// ****************************************
	// APB decode
	// ****************************************
	logic [7:0] idx;
	logic acc, wr_en, rd_en, lane0;
	logic [7:0] wb;
	logic bank_sel;
	logic [7:0] reg_idx;

	assign idx = paddr[9:2];
	assign acc = psel && penable;
	assign lane0 = pstrb[0];
	assign wb = pwdata[7:0];
	assign wr_en = acc && pwrite && lane0 && (paddr[ADDR_W-1:10] == '0);
	assign rd_en = psel && !penable && !pwrite; // Setup phase: data must stand by the access edge
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// mirrored registers fold bank bit away
	always_comb begin
		reg_idx = idx;
		if (idx[6:0] == IDX_INDIRECT_ACCESS_PORT[6:0] || idx[6:0] == IDX_PROGRAM_COUNTER_LOW[6:0]
			|| idx[6:0] == IDX_CORE_FLAGS[6:0] || idx[6:0] == IDX_INDIRECT_POINTER[6:0]
			|| idx[6:0] == IDX_PC_UPPER_HOLDING[6:0] || idx[6:0] == IDX_INTERRUPT_CONTROL[6:0]) begin
			reg_idx = {1'b1, idx[6:0]};
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] option_q, pcl_q, flags_q, ptr_q, pb_q, pc_q, intctl_q, pie_q, pr_q, sadd_q;
	logic [5:0] pa_q;
	logic [4:0] pch_hold_q, pch_q;
	logic [1:0] power_reset_cause_q;
	logic pc_load;

	assign bank_sel = flags_q[CORE_FLAGS_BANK_BIT];
	assign pc_load = wr_en && reg_idx == IDX_PROGRAM_COUNTER_LOW;

	// plain configuration registers, same value on every reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_q <= RST_OPTION_CONFIG;
			pa_q <= RST_PORT_A_DIRECTION;
			pb_q <= RST_PORT_B_DIRECTION;
			pc_q <= RST_PORT_C_DIRECTION;
			pie_q <= RST_PERIPHERAL_IRQ_ENABLE;
			pr_q <= RST_TIMER_PERIOD;
			sadd_q <= RST_SERIAL_SLAVE_ADDRESS;
			pch_hold_q <= RST_PC_UPPER_HOLDING;
		end else if (other_reset) begin
			option_q <= RST_OPTION_CONFIG;
			pa_q <= RST_PORT_A_DIRECTION;
			pb_q <= RST_PORT_B_DIRECTION;
			pc_q <= RST_PORT_C_DIRECTION;
			pie_q <= RST_PERIPHERAL_IRQ_ENABLE;
			pr_q <= RST_TIMER_PERIOD;
			sadd_q <= RST_SERIAL_SLAVE_ADDRESS;
			pch_hold_q <= RST_PC_UPPER_HOLDING;
		end else if (wr_en) begin
			unique case (reg_idx)
				IDX_OPTION_CONFIG: option_q <= wb;
				IDX_PORT_A_DIRECTION: pa_q <= wb[5:0];
				IDX_PORT_B_DIRECTION: pb_q <= wb;
				IDX_PORT_C_DIRECTION: pc_q <= wb;
				IDX_PERIPHERAL_IRQ_ENABLE: pie_q <= wb;
				IDX_TIMER_PERIOD: pr_q <= wb;
				IDX_SERIAL_SLAVE_ADDRESS: sadd_q <= wb;
				IDX_PC_UPPER_HOLDING: pch_hold_q <= wb[4:0];
				default: ;
			endcase
		end
	end

	// program counter; upper bits only follow the latch on a load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcl_q <= RST_PROGRAM_COUNTER_LOW;
			pch_q <= RST_PC_UPPER_HOLDING;
		end else if (other_reset) begin
			pcl_q <= RST_PROGRAM_COUNTER_LOW;
			pch_q <= RST_PC_UPPER_HOLDING;
		end else if (pc_load) begin
			pcl_q <= wb;
			pch_q <= pch_hold_q;
		end
	end

	// core flags, pointer and interrupt control: other resets clear flags bits 7:5 and control bits 7:1, keep the rest
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= RST_CORE_FLAGS_POR;
			ptr_q <= RST_INDIRECT_POINTER;
			intctl_q <= RST_INTERRUPT_CONTROL;
		end else if (other_reset) begin
			flags_q <= flags_q & CORE_FLAGS_OTHER_CLEAR;
			intctl_q <= intctl_q & INTCTL_KEEP_MASK;
		end else if (wr_en) begin
			unique case (reg_idx)
				IDX_CORE_FLAGS: flags_q <= wb;
				IDX_INDIRECT_POINTER: ptr_q <= wb;
				IDX_INTERRUPT_CONTROL: intctl_q <= wb;
				default: ;
			endcase
		end
	end

	// reset cause: power-on clears both, brown-out clears its bit
	// software sets them, pin or watchdog leaves them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_reset_cause_q <= 2'b00;
		end else if (brownout_detect) begin
			power_reset_cause_q[PWR_BOR_BIT] <= 1'b0;
		end else if (wr_en && reg_idx == IDX_POWER_RESET_CAUSE) begin
			power_reset_cause_q <= wb[1:0];
		end
	end

	// ****************************************
	// Indirect access
	// ****************************************
	logic ind_hit;
	assign ind_hit = reg_idx == IDX_INDIRECT_ACCESS_PORT;

	// pointer addresses data memory, indirect bank from core flags bit 7
	assign mem_addr = {flags_q[7], ptr_q};
	assign mem_wr = wr_en && ind_hit;
	assign mem_rd = rd_en && ind_hit;
	assign mem_wdata = wb;

	// ****************************************
	// Events and interrupt
	// ****************************************
	logic [EV_WIDTH-1:0] ev_stat_q, ev_mask_q, ev_in;
	logic mapped;

	assign ev_in = {acc && !mapped, other_reset, pc_load};

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_stat_q <= '0;
			ev_mask_q <= '0;
		end else begin
			if (wr_en && idx == IDX_EVENT_STATUS) begin
				ev_stat_q <= (ev_stat_q & ~wb[EV_WIDTH-1:0]) | ev_in;
			end else begin
				ev_stat_q <= ev_stat_q | ev_in;
			end
			if (wr_en && idx == IDX_EVENT_MASK) begin
				ev_mask_q <= wb[EV_WIDTH-1:0];
			end
		end
	end

	assign irq = |(ev_stat_q & ev_mask_q);

	// ****************************************
	// Read mux
	// ****************************************
	logic [7:0] rd_byte;

	// unmapped locations and unused bits read zero
	always_comb begin
		rd_byte = 8'h00;
		mapped = 1'b1;
		unique case (reg_idx)
			IDX_INDIRECT_ACCESS_PORT: rd_byte = mem_rdata;
			IDX_OPTION_CONFIG: rd_byte = option_q;
			IDX_PROGRAM_COUNTER_LOW: rd_byte = pcl_q;
			IDX_CORE_FLAGS: rd_byte = flags_q;
			IDX_INDIRECT_POINTER: rd_byte = ptr_q;
			IDX_PORT_A_DIRECTION: rd_byte = {2'b00, pa_q};
			IDX_PORT_B_DIRECTION: rd_byte = pb_q;
			IDX_PORT_C_DIRECTION: rd_byte = pc_q;
			IDX_PC_UPPER_HOLDING: rd_byte = {3'b000, pch_hold_q};
			IDX_INTERRUPT_CONTROL: rd_byte = intctl_q;
			IDX_PERIPHERAL_IRQ_ENABLE: rd_byte = pie_q;
			IDX_POWER_RESET_CAUSE: rd_byte = {6'b000000, power_reset_cause_q};
			IDX_TIMER_PERIOD: rd_byte = pr_q;
			IDX_SERIAL_SLAVE_ADDRESS: rd_byte = sadd_q;
			IDX_SERIAL_PORT_FLAGS: rd_byte = serial_flags_in & SERIAL_FLAGS_MASK;
			IDX_EVENT_STATUS: rd_byte = {5'b00000, ev_stat_q};
			IDX_EVENT_MASK: rd_byte = {5'b00000, ev_mask_q};
			default: mapped = 1'b0;
		endcase
		if (paddr[ADDR_W-1:10] != '0) begin
			rd_byte = 8'h00;
			mapped = 1'b0;
		end
	end

	// Read data fetched in the setup cycle, so it stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_en) begin
			prdata <= {24'h000000, rd_byte};
		end
	end

	// Register-driven outputs
	assign program_counter = {pch_q, pcl_q};
	assign option_out = option_q;
	assign port_a_dir = pa_q;
	assign port_b_dir = pb_q;
	assign port_c_dir = pc_q;
	assign irq_enable_out = pie_q;
	assign timer_period_out = pr_q;
	assign serial_addr_out = sadd_q;
	// Bank select is kept for the core; not used by this map
	logic unused_bank;
	assign unused_bank = bank_sel;
endmodule
`default_nettype wire

// ### test/sfrb_bank_chk.sv
// Checker for the bank-1 register map, bound to the top module.
// Assumes zero-wait APB, one register per aligned word.
`timescale 1ns/1ps
`default_nettype none
module sfrb_bank_chk
	import sfrb_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic watchdog_timeout,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [7:0] mem_wdata,
	input wire logic [12:0] program_counter,
	input wire logic [7:0] option_out,
	input wire logic [5:0] port_a_dir
);
	// ****************************************
	// Access decode
	// ****************************************
	logic acc_w;
	logic acc_r;
	// Writes in their access phase, reads in the setup cycle that fetches the data
	assign acc_w = psel && penable && pwrite && pstrb[0];
	assign acc_r = psel && !penable && !pwrite;
	function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a == ADDR_W'({idx, 2'b00});
	endfunction
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************
	// Assertions
	// ****************************************
	a_ready_no_error: assert property (pready && !pslverr)
		else $error("bus answer stalled or flagged an error");
	a_option_write: assert property (acc_w && at(paddr, IDX_OPTION_CONFIG)
		|=> option_out == $past(pwdata[7:0])) else $error("option write lost");
	a_dir_a_write: assert property (acc_w && at(paddr, IDX_PORT_A_DIRECTION)
		|=> port_a_dir == $past(pwdata[5:0])) else $error("port a direction write lost");
	a_pc_low_load: assert property (acc_w && at(paddr, IDX_PROGRAM_COUNTER_LOW)
		|=> program_counter[7:0] == $past(pwdata[7:0])) else $error("counter low not loaded");
	a_pc_upper_hold: assert property (acc_w && at(paddr, IDX_PC_UPPER_HOLDING)
		|=> $stable(program_counter[12:8])) else $error("counter upper moved on latch write");
	a_ind_write: assert property (acc_w && at(paddr, IDX_INDIRECT_ACCESS_PORT)
		|-> mem_wr && mem_wdata == pwdata[7:0]) else $error("indirect write not passed on");
	a_ind_read: assert property (acc_r && at(paddr, IDX_INDIRECT_ACCESS_PORT)
		|-> mem_rd && !mem_wr) else $error("indirect read not passed on");
	a_unmapped_zero: assert property (acc_r && at(paddr, 8'h88)
		|=> prdata == 32'h00000000) else $error("unmapped read not zero");
	a_wdog_reload: assert property (watchdog_timeout
		|-> ##[1:4] option_out == 8'hff) else $error("watchdog reset did not reload");
	a_por_values: assert property ($rose(presetn) |-> option_out == RST_OPTION_CONFIG
		&& port_a_dir == RST_PORT_A_DIRECTION && program_counter == 13'h0000)
		else $error("power-on values wrong");
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the bank-1 register map over APB.
// Assumes sfrb_pkg, sfrb_bank and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sfrb_pkg::*;
	typedef struct packed {logic [7:0] idx; logic [7:0] rst; logic [7:0] wd; logic [7:0] ex;} sfrb_row_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pin_n = 1'b1, wdog = 1'b0, bod = 1'b0, pready, pslverr, irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] pstrb = 4'hf;
	logic [7:0] mem_rdata = 8'h00;
	logic [8:0] mem_addr;
	logic [12:0] pc;
	logic [7:0] pb_dir, pc_dir, irq_en, tper, ser_addr;
	int err_count = 0, total_checks = 0;
	// Reset read, written value, read-back; unmapped places and mirrors included
	// port A direction top bits kept zero, reset cause top bits kept zero
	sfrb_row_t rows [16] = '{'{8'h81, 8'hff, 8'h5a, 8'h5a}, '{8'h84, 8'h00, 8'h3c, 8'h3c},
		'{8'h85, 8'h3f, 8'hff, 8'h3f}, '{8'h86, 8'hff, 8'h0f, 8'h0f}, '{8'h87, 8'hff, 8'ha5, 8'ha5},
		'{8'h8a, 8'h00, 8'hff, 8'h1f}, '{8'h0a, 8'h1f, 8'h15, 8'h15}, '{8'h0b, 8'h00, 8'ha5, 8'ha5},
		'{8'h8c, 8'h00, 8'h3c, 8'h3c}, '{8'h8e, 8'h00, 8'hff, 8'h03}, '{8'h92, 8'hff, 8'h77, 8'h77},
		'{8'h93, 8'h00, 8'h42, 8'h42}, '{8'h94, 8'h3f, 8'hff, 8'h3f}, '{8'h88, 8'h00, 8'hff, 8'h00},
		'{8'h8d, 8'h00, 8'hff, 8'h00}, '{8'h95, 8'h00, 8'hff, 8'h00}};
	sfrb_bank #(.ADDR_W(12)) sfrb_bank_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .external_reset_pin_n(pin_n),
		.watchdog_timeout(wdog), .brownout_detect(bod), .mem_addr(mem_addr), .mem_wr(),
		.mem_rd(), .mem_wdata(), .mem_rdata(mem_rdata), .program_counter(pc), .option_out(),
		.port_a_dir(), .port_b_dir(pb_dir), .port_c_dir(pc_dir), .irq_enable_out(irq_en),
		.timer_period_out(tper), .serial_addr_out(ser_addr), .serial_flags_in(8'hff), .irq(irq));
	// 40 MHz clock
	always #12.5 pclk = ~pclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; read data taken at the edge that completes it
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		r = prdata;
		#1;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, {2'b00, idx, 2'b00}, d);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		xfer(1'b0, {2'b00, idx, 2'b00}, 8'h00);
		chk(r, {24'h0, e});
	endtask
	// Interrupt line after its status has had a cycle to settle
	task automatic irq_is(input logic e);
		@(posedge pclk);
		#1;
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task automatic test_done();
		if (err_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles the run needs
	initial begin
		#125000;
		err_count++;
		test_done();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(IDX_CORE_FLAGS, RST_CORE_FLAGS_POR);
		foreach (rows[i]) begin
			rd(rows[i].idx, rows[i].rst);
			wr(rows[i].idx, rows[i].wd);
			rd(rows[i].idx, rows[i].ex);
		end
		chk({pb_dir, pc_dir, irq_en, tper}, {8'h0f, 8'ha5, 8'h3c, 8'h77});
		chk({24'h0, ser_addr}, 32'h42);
		// upper bits move only with the counter load
		wr(IDX_PC_UPPER_HOLDING, 8'h12);
		chk({19'h0, pc}, 32'h0);
		wr(IDX_PROGRAM_COUNTER_LOW, 8'h34);
		chk({19'h0, pc}, 32'h1234);
		// indirect port goes through the pointer
		wr(IDX_INDIRECT_POINTER, 8'h55);
		chk({23'h0, mem_addr}, 32'h55);
		rd(8'h04, 8'h55);
		@(posedge pclk) mem_rdata <= 8'ha7;
		rd(IDX_INDIRECT_ACCESS_PORT, 8'ha7);
		wr(IDX_INDIRECT_ACCESS_PORT, 8'h3c);
		rd(IDX_INDIRECT_ACCESS_PORT, 8'ha7);
		// Events: refused access raises, masks and clears
		wr(IDX_EVENT_STATUS, 8'h07);
		rd(IDX_EVENT_STATUS, 8'h00);
		wr(IDX_EVENT_MASK, 8'h04);
		xfer(1'b1, 12'h604, 8'h00);
		irq_is(1'b1);
		rd(IDX_EVENT_STATUS, 8'h04);
		rd(IDX_OPTION_CONFIG, 8'h5a);
		wr(IDX_EVENT_MASK, 8'h00);
		irq_is(1'b0);
		wr(IDX_EVENT_MASK, 8'h04);
		irq_is(1'b1);
		wr(IDX_EVENT_STATUS, 8'h04);
		irq_is(1'b0);
		// Byte strobe off: the write must not land
		@(posedge pclk) pstrb <= 4'he;
		wr(IDX_OPTION_CONFIG, 8'h00);
		@(posedge pclk) pstrb <= 4'hf;
		rd(IDX_OPTION_CONFIG, 8'h5a);
		// watchdog and pin resets reload, cause bits kept across the watchdog
		wr(IDX_EVENT_STATUS, 8'h07);
		@(posedge pclk) wdog <= 1'b1;
		@(posedge pclk) wdog <= 1'b0;
		repeat (3) @(posedge pclk);
		rd(IDX_OPTION_CONFIG, 8'hff);
		rd(IDX_CORE_FLAGS, 8'h18);
		rd(IDX_POWER_RESET_CAUSE, 8'h03);
		rd(IDX_EVENT_STATUS, 8'h02);
		chk({19'h0, pc}, 32'h0);
		wr(IDX_OPTION_CONFIG, 8'h00);
		@(posedge pclk) pin_n <= 1'b0;
		repeat (4) @(posedge pclk);
		pin_n <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(IDX_OPTION_CONFIG, 8'hff);
		@(posedge pclk) bod <= 1'b1;
		@(posedge pclk) bod <= 1'b0;
		rd(IDX_POWER_RESET_CAUSE, 8'h02);
		test_done();
	end
endmodule
bind sfrb_bank sfrb_bank_chk #(.ADDR_W(ADDR_W)) sfrb_bank_chk_i (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.watchdog_timeout(watchdog_timeout), .mem_wr(mem_wr), .mem_rd(mem_rd),
	.mem_wdata(mem_wdata), .program_counter(program_counter), .option_out(option_out),
	.port_a_dir(port_a_dir));
`default_nettype wire
